// ==== design/fsx_pkg.sv ====
// Behaviour
// [RULE_01] Sixteen 32-bit float registers, addressed by a 4-bit designator.
// [RULE_02] Float register zero is the implicit index of multiply-accumulate.
// [RULE_03] CPU data moves only through the 32-bit transfer register.
// [RULE_04] Only one rounding mode: every result rounds toward zero.
// [RULE_05] Denormal sources and results become zero, except for copies.
// [RULE_06] Invalid cause at bit 16, divide-by-zero cause at 15, per instruction.
// [RULE_07] Invalid enable at bit 11, divide-by-zero enable at 10, writable.
// [RULE_08] Sticky flags at bits 6 and 5, cleared only by register write.
// [RULE_09] All other control bits are fixed and ignore register loads.
// [RULE_10] Exception taken when a cause bit and its enable are both set.
// [RULE_11] Invalid with exception disabled gives quiet NaN; compare, truncate exempt.
// [RULE_12] Divide by zero with exception disabled gives correctly signed infinity.
// [RULE_13] Signaling NaN input with invalid enabled traps, destination unchanged.
// [RULE_14] Quiet NaN input without signaling NaN gives quiet NaN, no exception.
// [RULE_15] Max exponent with nonzero mantissa is NaN; bit 22 set means signaling.
// [RULE_16] Exponent bias 127, normal exponents from -126 up to 127.
// [RULE_17] Infinities and zeros use the fixed single-precision bit patterns.
// [RULE_18] Overflow gives signed max finite, underflow signed zero, no exception.
// [RULE_19] All float exceptions use one event at one fixed vector code.
// [RULE_20] Float data in memory sits on four-byte aligned addresses.
// [RULE_21] Issue in order; CPU-touching float operations synchronise with CPU.
// [RULE_22] Float exception cancels later CPU work; later faults let it finish.
// [RULE_23] Scoreboard of pending destinations stalls readers and writers.
package fsx_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int REG_COUNT  = 16;
  localparam int REG_ADDR_W = 4;
  localparam int DATA_W     = 32;
  localparam int EXC_CODE_W = 12;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam int CTRL_INV_CAUSE_BIT = 16;
  localparam int CTRL_DZ_CAUSE_BIT  = 15;
  localparam int CTRL_INV_EN_BIT    = 11;
  localparam int CTRL_DZ_EN_BIT     = 10;
  localparam int CTRL_INV_FLAG_BIT  = 6;
  localparam int CTRL_DZ_FLAG_BIT   = 5;
  // Fixed bits 18 and 0 read one; no rounding-mode field exists
  localparam logic [DATA_W-1:0] CTRL_FIXED_BITS = 32'h0004_0001;

  localparam logic [EXC_CODE_W-1:0] EXC_VECTOR   = 12'h120;
  localparam logic [REG_ADDR_W-1:0] FR_ZERO_ADDR = 4'h0;

  // ****************************************
  // Single-precision format
  // ****************************************
  localparam int SIGN_BIT = 31;
  localparam int EXP_MSB  = 30;
  localparam int EXP_LSB  = 23;
  localparam int MANT_MSB = 22;
  localparam int SNAN_BIT = 22;
  localparam logic [7:0] EXP_ALL_ONES  = 8'hFF;
  localparam logic [7:0] EXP_ALL_ZERO  = 8'h00;
  localparam logic [7:0] EXP_BIAS      = 8'h7F;
  localparam logic [7:0] EXP_MIN_NORM  = 8'h01;
  localparam logic [7:0] EXP_MAX_NORM  = 8'hFE;
  localparam logic [DATA_W-1:0] POS_ZERO  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] NEG_ZERO  = 32'h8000_0000;
  localparam logic [DATA_W-1:0] POS_INF   = 32'h7F80_0000;
  localparam logic [DATA_W-1:0] NEG_INF   = 32'hFF80_0000;
  localparam logic [DATA_W-1:0] QUIET_NAN = 32'h7FBF_FFFF;
  localparam logic [DATA_W-1:0] MAX_FIN   = 32'h7F7F_FFFF;

  // ****************************************
  // Commands and states
  // ****************************************
  typedef enum logic [3:0] {
    OP_COPY, OP_ARITH1, OP_ARITH2, OP_DIV, OP_MULACC, OP_COMPARE,
    OP_TRUNCATE, OP_FLOAT, OP_REG_TO_XFER, OP_XFER_TO_REG,
    OP_SYSLOAD_XFER, OP_SYSSTORE_XFER, OP_SYSLOAD_CTRL, OP_SYSSTORE_CTRL
  } fsx_op_e;

  typedef enum logic {ST_IDLE, ST_BUSY} fsx_state_e;

  // ****************************************
  // Value classification
  // ****************************************
  function automatic logic fsxIsNan(input logic [DATA_W-1:0] v);
    fsxIsNan = (v[EXP_MSB:EXP_LSB] == EXP_ALL_ONES) && (v[MANT_MSB:0] != '0);
  endfunction : fsxIsNan

  function automatic logic fsxIsSnan(input logic [DATA_W-1:0] v);
    fsxIsSnan = fsxIsNan(v) && v[SNAN_BIT];
  endfunction : fsxIsSnan

  function automatic logic fsxIsInf(input logic [DATA_W-1:0] v);
    fsxIsInf = (v[EXP_MSB:EXP_LSB] == EXP_ALL_ONES) && (v[MANT_MSB:0] == '0);
  endfunction : fsxIsInf

  function automatic logic fsxIsZero(input logic [DATA_W-1:0] v);
    fsxIsZero = (v[EXP_MSB:EXP_LSB] < EXP_MIN_NORM); // RULE_16
  endfunction : fsxIsZero

  // Denormals collapse to a zero of the same sign
  function automatic logic [DATA_W-1:0] fsxFlush(input logic [DATA_W-1:0] v);
    fsxFlush = fsxIsZero(v) ? (v[SIGN_BIT] ? NEG_ZERO : POS_ZERO) : v;
  endfunction : fsxFlush

endpackage : fsx_pkg

// ==== design/fsx_regfile.sv ====
`timescale 1ns/1ps
module fsx_regfile
  import fsx_pkg::*;
#(
  parameter int COUNT  = REG_COUNT,
  parameter int ADDR_W = REG_ADDR_W
) (
  input  wire logic              mclk,      // Core clock
  input  wire logic              wrEn,      // Write strobe
  input  wire logic [ADDR_W-1:0] wrAddr,    // Write designator
  input  wire logic [DATA_W-1:0] wrData,    // Write value
  input  wire logic [ADDR_W-1:0] rdAddrA,   // Read designator A
  output logic      [DATA_W-1:0] rdDataA,   // Read value A
  input  wire logic [ADDR_W-1:0] rdAddrB,   // Read designator B
  output logic      [DATA_W-1:0] rdDataB,   // Read value B
  output logic      [DATA_W-1:0] rdDataZero // Index register value
);

  logic [DATA_W-1:0] mem [COUNT];

  // Asynchronous reads; register zero has its own port
  assign rdDataA    = mem[rdAddrA];
  assign rdDataB    = mem[rdAddrB];
  assign rdDataZero = mem[FR_ZERO_ADDR]; // RULE_02

  // Contents are undefined after reset, so no reset here
  for (genvar i = 0; i < COUNT; i++) begin : g_entry
    logic [DATA_W-1:0] next_entry;
    always_comb begin
      next_entry = mem[i];
      if (wrEn && (wrAddr == ADDR_W'(i))) begin
        next_entry = wrData; // RULE_01 RULE_20
      end
    end
    always_ff @(posedge mclk) begin
      mem[i] <= next_entry;
    end
  end

endmodule : fsx_regfile

// ==== design/fsx_scoreboard.sv ====
`timescale 1ns/1ps
module fsx_scoreboard
  import fsx_pkg::*;
#(
  parameter int COUNT  = REG_COUNT,
  parameter int ADDR_W = REG_ADDR_W
) (
  input  wire logic              mclk,     // Core clock
  input  wire logic              rst_b,    // Async reset, active low
  input  wire logic              setEn,    // Destination becomes pending
  input  wire logic [ADDR_W-1:0] setAddr,  // Pending destination
  input  wire logic              clrEn,    // Producer completed
  input  wire logic [ADDR_W-1:0] clrAddr,  // Completed destination
  input  wire logic [ADDR_W-1:0] chkA,     // Register read or written
  input  wire logic [ADDR_W-1:0] chkB,     // Second register touched
  input  wire logic              chkZero,  // Index register also read
  output logic                   hazard    // Touches a pending register
);

  logic [COUNT-1:0] pend;

  // Any touched register still owed a result stalls the newcomer
  assign hazard = pend[chkA] | pend[chkB] |
                  (chkZero & pend[FR_ZERO_ADDR]); // RULE_23

  // One pending bit per register; set wins over a same-cycle clear
  for (genvar i = 0; i < COUNT; i++) begin : g_pend
    logic next_pend;
    always_comb begin
      next_pend = pend[i];
      if (clrEn && (clrAddr == ADDR_W'(i))) begin
        next_pend = 1'b0;
      end
      if (setEn && (setAddr == ADDR_W'(i))) begin
        next_pend = 1'b1; // RULE_23
      end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        pend[i] <= 1'b0;
      end else begin
        pend[i] <= next_pend;
      end
    end
  end

endmodule : fsx_scoreboard

// ==== design/fsx_unit.sv ====
`timescale 1ns/1ps
module fsx_unit
  import fsx_pkg::*;
(
  input  wire logic                  mclk,        // Core clock, 10 MHz
  input  wire logic                  rst_b,       // Async reset, active low
  // CPU issue side
  input  wire logic                  cpuValid,    // Instruction held
  input  wire fsx_op_e               cpuOp,       // Instruction class
  input  wire logic [REG_ADDR_W-1:0] cpuSrc,      // Source designator
  input  wire logic [REG_ADDR_W-1:0] cpuDst,      // Destination designator
  input  wire logic [DATA_W-1:0]     cpuWdata,    // System-load data
  output logic                       cpuAck,      // Instruction retired
  output logic [DATA_W-1:0]          cpuRdata,    // System-store data
  output logic                       cpuRdValid,  // Store data valid
  output logic                       cpuTflag,    // Compare outcome
  output logic                       cpuTvalid,   // Compare outcome valid
  output logic                       fpExcReq,    // Exception event
  output logic [EXC_CODE_W-1:0]      fpExcVector, // Exception vector code
  // Arithmetic datapath side
  output logic                       dpStart,     // Start operation
  output fsx_op_e                    dpOp,        // Operation class
  output logic [DATA_W-1:0]          dpOpA,       // Operand A
  output logic [DATA_W-1:0]          dpOpB,       // Operand B
  output logic [DATA_W-1:0]          dpOpC,       // Operand C (accumulate)
  input  wire logic                  dpDone,      // Operation finished
  input  wire logic [DATA_W-1:0]     dpResult,    // Truncated raw result
  input  wire logic                  dpOverflow,  // Result overflowed
  input  wire logic                  dpUnderflow, // Result underflowed
  input  wire logic                  dpInvalid,   // Operation was invalid
  input  wire logic                  dpCmpTrue    // Compare held true
);

  // ****************************************
  // State
  // ****************************************
  fsx_state_e              state, next_state;
  fsx_op_e                 curOp, next_curOp;
  logic [REG_ADDR_W-1:0]   curDst, next_curDst;
  logic [DATA_W-1:0]       xferReg, next_xferReg;
  logic causeInv, causeDz, enInv, enDz, flagInv, flagDz;
  logic next_causeInv, next_causeDz, next_enInv, next_enDz;
  logic next_flagInv, next_flagDz;
  logic                    next_cpuAck, next_cpuRdValid;
  logic                    next_cpuTflag, next_cpuTvalid;
  logic                    next_fpExcReq, next_dpStart;
  logic [DATA_W-1:0]       next_cpuRdata;
  fsx_op_e                 next_dpOp;
  logic [DATA_W-1:0]       next_dpOpA, next_dpOpB, next_dpOpC;

  logic [DATA_W-1:0]       rdDst, rdSrc, rdZero, ctrlWord;
  logic                    rfWrEn;
  logic [REG_ADDR_W-1:0]   rfWrAddr;
  logic [DATA_W-1:0]       rfWrData;
  logic                    hazard, busy, finish, take, blocked;
  logic                    usesDp, syncOp, asyncDp;

  // ****************************************
  // Register file and scoreboard
  // ****************************************
  fsx_regfile u_regfile (
    .mclk       (mclk),
    .wrEn       (rfWrEn),
    .wrAddr     (rfWrAddr),
    .wrData     (rfWrData),
    .rdAddrA    (cpuDst),
    .rdDataA    (rdDst),
    .rdAddrB    (cpuSrc),
    .rdDataB    (rdSrc),
    .rdDataZero (rdZero)
  );

  fsx_scoreboard u_scoreboard (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .setEn   (take && asyncDp),
    .setAddr (cpuDst),
    .clrEn   (finish),
    .clrAddr (curDst),
    .chkA    (cpuDst),
    .chkB    (cpuSrc),
    .chkZero (cpuOp == OP_MULACC),
    .hazard  (hazard)
  );

  // ****************************************
  // Issue control
  // ****************************************
  // Classify the held instruction
  always_comb begin
    usesDp = 1'b0;
    syncOp = 1'b0;
    unique case (cpuOp)
      OP_ARITH1, OP_ARITH2, OP_DIV, OP_MULACC: usesDp = 1'b1;
      OP_COMPARE, OP_TRUNCATE, OP_FLOAT: begin
        usesDp = 1'b1;
        syncOp = 1'b1; // RULE_21
      end
      OP_SYSLOAD_CTRL, OP_SYSSTORE_CTRL: syncOp = 1'b1;
      default: syncOp = 1'b0;
    endcase
  end

  assign asyncDp = usesDp && !syncOp && (cpuOp != OP_FLOAT);
  assign busy    = (state == ST_BUSY);
  assign finish  = busy && dpDone;
  // One datapath operation at a time; copies of idle registers may pass
  assign blocked = busy && (usesDp || syncOp || dpDone || hazard); // RULE_23
  // A held request is taken once; ack guards the retake
  assign take    = cpuValid && !cpuAck && !blocked; // RULE_21

  assign ctrlWord = CTRL_FIXED_BITS
                  | (DATA_W'(causeInv) << CTRL_INV_CAUSE_BIT)
                  | (DATA_W'(causeDz)  << CTRL_DZ_CAUSE_BIT)
                  | (DATA_W'(enInv)    << CTRL_INV_EN_BIT)
                  | (DATA_W'(enDz)     << CTRL_DZ_EN_BIT)
                  | (DATA_W'(flagInv)  << CTRL_INV_FLAG_BIT)
                  | (DATA_W'(flagDz)   << CTRL_DZ_FLAG_BIT); // RULE_09

  // ****************************************
  // Completion: special values and causes
  // ****************************************
  logic useA, useB, useC, snanIn, qnanIn, zeroByZero;
  logic doneInv, doneDz, doneTrap, resSign;
  logic [DATA_W-1:0] fixedResult;

  // Operands were flushed at issue; inspect them for NaNs
  always_comb begin
    useA = (curOp != OP_FLOAT);
    useB = (curOp == OP_ARITH2) || (curOp == OP_DIV) ||
           (curOp == OP_MULACC) || (curOp == OP_COMPARE);
    useC = (curOp == OP_MULACC);
    snanIn = (useA && fsxIsSnan(dpOpA)) || (useB && fsxIsSnan(dpOpB)) ||
             (useC && fsxIsSnan(dpOpC)); // RULE_15
    qnanIn = (useA && fsxIsNan(dpOpA)) || (useB && fsxIsNan(dpOpB)) ||
             (useC && fsxIsNan(dpOpC));
    zeroByZero = (curOp == OP_DIV) && fsxIsZero(dpOpA) &&
                 fsxIsZero(dpOpB);
    doneDz = (curOp == OP_DIV) && fsxIsZero(dpOpB) &&
             !fsxIsZero(dpOpA) && !fsxIsNan(dpOpA) && !fsxIsInf(dpOpA);
    // A quiet NaN alone never raises invalid
    doneInv = snanIn || (dpInvalid && !qnanIn) || zeroByZero; // RULE_14
    doneTrap = (doneInv && enInv) || (doneDz && enDz); // RULE_10
    resSign = dpResult[SIGN_BIT];
    // Datapath truncates; only round-toward-zero results reach here
    if (doneInv || qnanIn) begin
      fixedResult = QUIET_NAN; // RULE_11
    end else if (doneDz) begin
      fixedResult = (dpOpA[SIGN_BIT] ^ dpOpB[SIGN_BIT]) ?
                    NEG_INF : POS_INF; // RULE_12
    end else if (dpOverflow) begin
      fixedResult = MAX_FIN | (DATA_W'(resSign) << SIGN_BIT); // RULE_18
    end else if (dpUnderflow) begin
      fixedResult = resSign ? NEG_ZERO : POS_ZERO; // RULE_18 RULE_17
    end else begin
      fixedResult = fsxFlush(dpResult); // RULE_05 RULE_04
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  // Completion and issue never collide: issue is blocked on dpDone
  always_comb begin
    next_state      = state;
    next_curOp      = curOp;
    next_curDst     = curDst;
    next_xferReg    = xferReg;
    next_causeInv   = causeInv;
    next_causeDz    = causeDz;
    next_enInv      = enInv;
    next_enDz       = enDz;
    next_flagInv    = flagInv;
    next_flagDz     = flagDz;
    next_cpuAck     = 1'b0;
    next_cpuRdValid = 1'b0;
    next_cpuRdata   = cpuRdata;
    next_cpuTvalid  = 1'b0;
    next_cpuTflag   = cpuTflag;
    next_fpExcReq   = 1'b0;
    next_dpStart    = 1'b0;
    next_dpOp       = dpOp;
    next_dpOpA      = dpOpA;
    next_dpOpB      = dpOpB;
    next_dpOpC      = dpOpC;
    rfWrEn          = 1'b0;
    rfWrAddr        = cpuDst;
    rfWrData        = rdSrc;
    if (finish) begin
      // A later CPU fault does not stop the operation finishing
      next_state    = ST_IDLE; // RULE_22
      next_causeInv = doneInv; // RULE_06
      next_causeDz  = doneDz;
      next_flagInv  = flagInv | doneInv; // RULE_08
      next_flagDz   = flagDz | doneDz;
      if (doneTrap) begin
        // Destination kept; CPU cancels younger work on this event
        next_fpExcReq = 1'b1; // RULE_13 RULE_19 RULE_22
      end else if (curOp == OP_TRUNCATE) begin
        next_xferReg = dpResult; // RULE_11
      end else if (curOp != OP_COMPARE) begin
        rfWrEn   = 1'b1;
        rfWrAddr = curDst;
        rfWrData = fixedResult;
      end
      if ((curOp == OP_COMPARE) || (curOp == OP_TRUNCATE) ||
          (curOp == OP_FLOAT)) begin
        next_cpuAck = 1'b1; // RULE_21
      end
      if (curOp == OP_COMPARE) begin
        next_cpuTvalid = !doneTrap;
        next_cpuTflag  = dpCmpTrue && !qnanIn;
      end
    end
    if (take) begin
      next_cpuAck = !usesDp || !syncOp;
      unique case (cpuOp)
        OP_COPY: begin
          rfWrEn        = 1'b1; // Copies keep denormals as they are
          next_causeInv = 1'b0;
          next_causeDz  = 1'b0;
        end
        OP_XFER_TO_REG: begin
          rfWrEn        = 1'b1;
          rfWrData      = xferReg; // RULE_03
          next_causeInv = 1'b0;
          next_causeDz  = 1'b0;
        end
        OP_REG_TO_XFER: begin
          next_xferReg  = rdSrc; // RULE_03
          next_causeInv = 1'b0;
          next_causeDz  = 1'b0;
        end
        OP_SYSLOAD_XFER: next_xferReg = cpuWdata; // RULE_03
        OP_SYSSTORE_XFER: begin
          next_cpuRdata   = xferReg; // RULE_03
          next_cpuRdValid = 1'b1;
        end
        OP_SYSLOAD_CTRL: begin
          // Only cause, enable and flag fields are writable
          next_causeInv = cpuWdata[CTRL_INV_CAUSE_BIT]; // RULE_06
          next_causeDz  = cpuWdata[CTRL_DZ_CAUSE_BIT];
          next_enInv    = cpuWdata[CTRL_INV_EN_BIT]; // RULE_07
          next_enDz     = cpuWdata[CTRL_DZ_EN_BIT];
          next_flagInv  = cpuWdata[CTRL_INV_FLAG_BIT]; // RULE_08
          next_flagDz   = cpuWdata[CTRL_DZ_FLAG_BIT];
        end
        OP_SYSSTORE_CTRL: begin
          next_cpuRdata   = ctrlWord;
          next_cpuRdValid = 1'b1;
        end
        OP_ARITH1, OP_ARITH2, OP_DIV, OP_MULACC,
        OP_COMPARE, OP_TRUNCATE, OP_FLOAT: begin
          next_state   = ST_BUSY;
          next_curOp   = cpuOp;
          next_curDst  = cpuDst;
          next_dpStart = 1'b1;
          next_dpOp    = cpuOp;
          next_dpOpA   = fsxFlush(rdDst); // RULE_05
          next_dpOpB   = fsxFlush(rdSrc);
          next_dpOpC   = POS_ZERO;
          if ((cpuOp == OP_ARITH1) || (cpuOp == OP_TRUNCATE)) begin
            next_dpOpA = fsxFlush(rdSrc);
          end else if (cpuOp == OP_FLOAT) begin
            next_dpOpA = xferReg; // Integer source, no flush
          end else if (cpuOp == OP_MULACC) begin
            next_dpOpA = fsxFlush(rdZero); // RULE_02
            next_dpOpC = fsxFlush(rdDst);
          end
        end
        default: next_cpuAck = 1'b1; // Illegal code retires as no-op
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Control state resets to idle; fixed bits live in the constant
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      curOp       <= OP_COPY;
      curDst      <= '0;
      xferReg     <= '0;
      causeInv    <= 1'b0;
      causeDz     <= 1'b0;
      enInv       <= 1'b0;
      enDz        <= 1'b0;
      flagInv     <= 1'b0;
      flagDz      <= 1'b0;
      cpuAck      <= 1'b0;
      cpuRdValid  <= 1'b0;
      cpuRdata    <= '0;
      cpuTvalid   <= 1'b0;
      cpuTflag    <= 1'b0;
      fpExcReq    <= 1'b0;
      fpExcVector <= EXC_VECTOR;
      dpStart     <= 1'b0;
      dpOp        <= OP_COPY;
      dpOpA       <= '0;
      dpOpB       <= '0;
      dpOpC       <= '0;
    end else begin
      state       <= next_state;
      curOp       <= next_curOp;
      curDst      <= next_curDst;
      xferReg     <= next_xferReg;
      causeInv    <= next_causeInv;
      causeDz     <= next_causeDz;
      enInv       <= next_enInv;
      enDz        <= next_enDz;
      flagInv     <= next_flagInv;
      flagDz      <= next_flagDz;
      cpuAck      <= next_cpuAck;
      cpuRdValid  <= next_cpuRdValid;
      cpuRdata    <= next_cpuRdata;
      cpuTvalid   <= next_cpuTvalid;
      cpuTflag    <= next_cpuTflag;
      fpExcReq    <= next_fpExcReq;
      fpExcVector <= EXC_VECTOR; // RULE_19
      dpStart     <= next_dpStart;
      dpOp        <= next_dpOp;
      dpOpA       <= next_dpOpA;
      dpOpB       <= next_dpOpB;
      dpOpC       <= next_dpOpC;
    end
  end

endmodule : fsx_unit

// ==== verif/fsx_unit_props.sv ====
`timescale 1ns/1ps
module fsx_unit_props
  import fsx_pkg::*;
(
  input wire logic                  mclk,        // Clock
  input wire logic                  rst_b,       // Reset
  input wire logic                  cpuValid,    // Request
  input wire logic                  cpuAck,      // Retire
  input wire logic                  cpuRdValid,  // Read valid
  input wire logic                  cpuTvalid,   // Compare valid
  input wire logic                  fpExcReq,    // Exception
  input wire logic [EXC_CODE_W-1:0] fpExcVector, // Vector
  input wire logic                  dpStart,     // Start
  input wire logic [DATA_W-1:0]     dpOpA,       // Operand A
  input wire logic                  dpDone       // Done
);
  // Flushed operand A must never look denormal at start
  wire logic denA = (dpOpA[EXP_MSB:EXP_LSB] == EXP_ALL_ZERO) &&
                    (dpOpA[MANT_MSB:0] != '0);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_vector_fixed: assert property (fpExcVector == EXC_VECTOR)
    else $error("vector code changed");
  a_ack_single: assert property (cpuAck |=> !cpuAck)
    else $error("ack longer than one cycle");
  a_exc_single: assert property (fpExcReq |=> !fpExcReq)
    else $error("exception longer than one cycle");
  a_exc_done: assert property (fpExcReq |-> $past(dpDone))
    else $error("exception without completion");
  a_flush_opa: assert property (dpStart |-> !denA)
    else $error("denormal operand reached datapath");
  a_start_taken: assert property (
    dpStart |-> $past(cpuValid) && !$past(cpuAck))
    else $error("start without a taken request");
  a_tvalid_ack: assert property (cpuTvalid |-> cpuAck)
    else $error("compare result without retire");
  a_rdata_ack: assert property (cpuRdValid |-> cpuAck)
    else $error("store data without retire");
endmodule : fsx_unit_props
bind fsx_unit fsx_unit_props i_props (.mclk, .rst_b, .cpuValid, .cpuAck,
  .cpuRdValid, .cpuTvalid, .fpExcReq, .fpExcVector, .dpStart, .dpOpA, .dpDone);

// ==== verif/fsx_dp_model.sv ====
`timescale 1ns/1ps
module fsx_dp_model
  import fsx_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic              mclk,        // Clock
  input  wire logic              rst_b,       // Reset
  input  wire logic              dpStart,     // Start
  input  wire logic [DATA_W-1:0] dpOpA,       // Operand A
  input  wire logic [DATA_W-1:0] dpOpB,       // Operand B
  output logic                   dpDone,      // Done
  output logic      [DATA_W-1:0] dpResult,    // Raw result
  output logic                   dpOverflow,  // Overflow
  output logic                   dpUnderflow, // Underflow
  output logic                   dpInvalid,   // Invalid
  output logic                   dpCmpTrue    // Compare true
);
  int cnt;
  // One operation in flight, done LAT+1 cycles after its start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      dpDone <= 1'b0;
    end else begin
      dpDone <= (cnt == 1);
      cnt <= dpStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
  end
  // Outside done the result is junk, so stale reads show up
  assign dpResult = dpDone ? dpOpA : ~dpOpA;
  assign dpCmpTrue = dpDone && (dpOpA == dpOpB);
  assign dpOverflow = 1'b0;
  assign dpUnderflow = 1'b0;
  assign dpInvalid = 1'b0;
endmodule : fsx_dp_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import fsx_pkg::*;
;
  logic mclk, rst_b, cpuValid, cpuAck, cpuRdValid, cpuTflag, cpuTvalid;
  logic fpExcReq, dpStart, dpDone, dpOverflow, dpUnderflow, dpInvalid;
  logic dpCmpTrue, lastT;
  fsx_op_e cpuOp, dpOp;
  logic [REG_ADDR_W-1:0] cpuSrc, cpuDst;
  logic [DATA_W-1:0] cpuWdata, cpuRdata, dpOpA, dpOpB, dpOpC, dpResult;
  logic [DATA_W-1:0] lastRd;
  logic [EXC_CODE_W-1:0] fpExcVector;
  int fails = 0, comparisons = 0, excCount = 0;
  fsx_unit i_dut (.mclk, .rst_b, .cpuValid, .cpuOp, .cpuSrc, .cpuDst,
    .cpuWdata, .cpuAck, .cpuRdata, .cpuRdValid, .cpuTflag, .cpuTvalid,
    .fpExcReq, .fpExcVector, .dpStart, .dpOp, .dpOpA, .dpOpB, .dpOpC,
    .dpDone, .dpResult, .dpOverflow, .dpUnderflow, .dpInvalid, .dpCmpTrue);
  fsx_dp_model i_dp (.mclk, .rst_b, .dpStart, .dpOpA, .dpOpB, .dpDone,
    .dpResult, .dpOverflow, .dpUnderflow, .dpInvalid, .dpCmpTrue);
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Hold the request until retire is seen, then drop it
  task automatic issue(fsx_op_e op, logic [3:0] s, d, logic [31:0] w);
    int n = 0;
    @(negedge mclk);
    cpuOp = op;
    cpuSrc = s;
    cpuDst = d;
    cpuWdata = w;
    cpuValid = 1'b1;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (cpuAck !== 1'b1 && n < 400);
    fails += (n >= 400);
    lastRd = cpuRdata;
    lastT = cpuTflag && cpuTvalid;
    @(negedge mclk);
    cpuValid = 1'b0;
  endtask : issue
  task automatic wrFr(logic [3:0] r, logic [31:0] v);
    issue(OP_SYSLOAD_XFER, 4'h0, 4'h0, v);
    issue(OP_XFER_TO_REG, r, r, 32'h0);
  endtask : wrFr
  task automatic rdFr(logic [3:0] r);
    issue(OP_REG_TO_XFER, r, r, 32'h0);
    issue(OP_SYSSTORE_XFER, 4'h0, 4'h0, 32'h0);
  endtask : rdFr
  task automatic rdCtrl();
    issue(OP_SYSSTORE_CTRL, 4'h0, 4'h0, 32'h0);
  endtask : rdCtrl
  task automatic t_ctrl();
    rdCtrl();
    check("ctrl reset", lastRd, CTRL_FIXED_BITS);
    issue(OP_SYSLOAD_CTRL, 4'h0, 4'h0, 32'hFFFF_FFFF);
    rdCtrl();
    check("ctrl ones", lastRd, 32'h0005_8C61);
    issue(OP_SYSLOAD_CTRL, 4'h0, 4'h0, 32'h0);
    rdCtrl();
    check("ctrl clear", lastRd, CTRL_FIXED_BITS);
  endtask : t_ctrl
  task automatic t_divzero();
    for (int i = 0; i < 2; i++) begin
      wrFr(4'h1, i ? 32'hBF80_0000 : 32'h3F80_0000);
      wrFr(4'h2, POS_ZERO);
      issue(OP_DIV, 4'h2, 4'h1, 32'h0);
      rdCtrl();
      check("dz ctrl", lastRd, 32'h0004_8021);
      rdFr(4'h1);
      check("dz result", lastRd, i ? NEG_INF : POS_INF);
    end
    rdCtrl();
    check("dz sticky", lastRd, 32'h0004_0021);
    check("dz traps", 32'(excCount), 32'd0);
  endtask : t_divzero
  task automatic t_nan();
    issue(OP_SYSLOAD_CTRL, 4'h0, 4'h0, 32'h0000_0800);
    wrFr(4'h3, 32'h3F80_0000);
    wrFr(4'h4, 32'h7FC0_0000);
    issue(OP_ARITH2, 4'h4, 4'h3, 32'h0);
    rdCtrl();
    check("snan ctrl", lastRd, 32'h0005_0841);
    check("snan traps", 32'(excCount), 32'd1);
    rdFr(4'h3);
    check("snan dest", lastRd, 32'h3F80_0000);
    wrFr(4'h5, 32'h7F80_0001);
    issue(OP_ARITH2, 4'h5, 4'h3, 32'h0);
    rdCtrl();
    check("qnan ctrl", lastRd, 32'h0004_0841);
    rdFr(4'h3);
    check("qnan result", lastRd, QUIET_NAN);
    check("qnan traps", 32'(excCount), 32'd1);
    issue(OP_COMPARE, 4'h1, 4'h1, 32'h0);
    check("cmp equal", 32'(lastT), 32'd1);
    wrFr(4'h0, 32'h4000_0000);
    issue(OP_MULACC, 4'h2, 4'h2, 32'h0);
    rdFr(4'h2);
    check("mac index", lastRd, 32'h4000_0000);
    wrFr(4'h0, 32'h0000_0001);
    issue(OP_COPY, 4'h0, 4'h6, 32'h0);
    rdFr(4'h6);
    check("copy denorm", lastRd, 32'h0000_0001);
  endtask : t_nan
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Exception pulses, counted so traps can be compared afterwards
  always @(posedge mclk) begin
    if (fpExcReq === 1'b1) excCount++;
  end
  initial begin
    {rst_b, cpuValid, cpuSrc, cpuDst, cpuWdata} = '0;
    cpuOp = OP_COPY;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    t_ctrl();
    t_divzero();
    t_nan();
    give_verdict();
  end
  // Whole run needs far fewer than 4000 cycles
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule : testbench
